// ==== hw/spd_step_decoder.sv ====
// Step pulse input decoder with excitation position tracking and APB registers.
// Assumes pin inputs are asynchronous photocoupler levels, high meaning ON.
//
// Summary of operation
// - Every pin level is the photocoupler state; high means conducting.
// - Single mode, direction active: pulse falling edge steps once clockwise.
// - Single mode, direction inactive: pulse falling edge steps once counter-clockwise.
// - Dual mode: falling edge on clockwise input steps once clockwise; the decoder takes no step when both inputs fall in one cycle.
// - Dual mode: falling edge on counter-clockwise input steps once counter-clockwise; the decoder takes no step when both inputs fall in one cycle.
// - Winding release active cuts all winding current.
// - Winding release inactive restores winding current.
// - Resolution select picks secondary setting when active, primary otherwise.
// - Home flag is on whenever excitation counter is zero.
// - Excitation counter starts at home after power-up.
// - Home flag recurs every ten full steps, any resolution.
// - Dual mode pulse inputs share the single mode pulse and direction pins.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "spd_cfg.svh"

module spd_step_decoder #(
    parameter int IDLE_CYCLES = `SPD_IDLE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pulse_pin_a,
    input wire logic pulse_pin_b,
    input wire logic windings_release,
    input wire logic resolution_select,
    output logic step_cw,
    output logic step_ccw,
    output logic winding_enable,
    output logic standstill_current,
    output logic excitation_home_flag,
    output logic [11:0] excitation_position
);

    localparam int SETUP_CYCLES = (`SPD_DIR_SETUP_NS * `SPD_CLK_MHZ + 999) / 1000;
    localparam logic [11:0] SETUP_MAX = 12'(SETUP_CYCLES);
    localparam logic [15:0] IDLE_MAX = 16'(IDLE_CYCLES);

    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
        addr_hit = (addr == off);
    endfunction

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [3:0] pins_in;
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [3:0] prev_ff;

    assign pins_in = {resolution_select, windings_release, pulse_pin_b, pulse_pin_a};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_ff[gi] <= 1'b0;
                    sync2_ff[gi] <= 1'b0;
                    prev_ff[gi] <= 1'b0;
                end else begin
                    sync1_ff[gi] <= pins_in[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                    prev_ff[gi] <= sync2_ff[gi];
                end
            end
        end
    endgenerate

    wire a_level = sync2_ff[0];
    wire b_level = sync2_ff[1];
    wire rel_level = sync2_ff[2];
    wire res_level = sync2_ff[3];
    wire a_fall = prev_ff[0] & ~a_level;
    wire b_fall = prev_ff[1] & ~b_level;
    wire b_edge = prev_ff[1] ^ b_level;

    // ------------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------------
    spd_pkg::spd_mode_e mode_ff;
    spd_pkg::spd_setting_t primary_ff;
    spd_pkg::spd_setting_t secondary_ff;
    logic [31:0] steps_ff;
    logic [1:0] flags_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    wire setup_phase = psel & ~penable;
    wire wr_en = psel & penable & pwrite & pready_ff;
    wire hit_ctrl = addr_hit(paddr, `SPD_ADDR_CTRL);
    wire hit_status = addr_hit(paddr, `SPD_ADDR_STATUS);
    wire hit_steps = addr_hit(paddr, `SPD_ADDR_STEPS);
    wire hit_flags = addr_hit(paddr, `SPD_ADDR_FLAGS);
    wire hit_any = hit_ctrl | hit_status | hit_steps | hit_flags;
    wire wr_ctrl = wr_en & hit_ctrl;
    wire wr_steps = wr_en & hit_steps;
    wire wr_flags = wr_en & hit_flags;
    wire dual = (mode_ff == spd_pkg::SPD_DUAL);

    // ------------------------------------------------------------------------
    // Step decode
    // ------------------------------------------------------------------------
    logic cw_req;
    logic ccw_req;
    logic step_any;

    always_comb begin
        if (dual) begin
            cw_req = a_fall & ~b_fall;
            ccw_req = b_fall & ~a_fall;
        end else begin
            cw_req = a_fall & b_level;
            ccw_req = a_fall & ~b_level;
        end
        step_any = cw_req | ccw_req;
    end

    // ------------------------------------------------------------------------
    // Excitation position counter
    // ------------------------------------------------------------------------
    spd_pkg::spd_pos_t wrap_q;
    spd_pkg::spd_pos_t pos_ff;
    spd_pkg::spd_pos_t pos_up;
    spd_pkg::spd_pos_t pos_dn;
    spd_pkg::spd_pos_t nxt_pos;
    spd_pkg::spd_setting_t sel_setting;

    assign sel_setting = res_level ? secondary_ff : primary_ff;

    spd_wrap_rom u_wrap_rom (
        .pclk(pclk),
        .presetn(presetn),
        .setting(sel_setting),
        .wrap_ff(wrap_q)
    );

    wire [11:0] wrap_last = wrap_q - 12'h001;

    assign pos_up = (pos_ff >= wrap_last) ? `SPD_RST_POS : pos_ff + 12'h001;
    assign pos_dn = (pos_ff == `SPD_RST_POS || pos_ff > wrap_last) ?
                    wrap_last : pos_ff - 12'h001;
    assign nxt_pos = cw_req ? pos_up : (ccw_req ? pos_dn : pos_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_ff <= `SPD_RST_POS;
        end else begin
            pos_ff <= nxt_pos;
        end
    end

    // ------------------------------------------------------------------------
    // Direction setup and overlap monitors
    // ------------------------------------------------------------------------
    logic [11:0] setup_cnt_ff;
    logic last_dir_ff;
    logic [11:0] nxt_setup_cnt;

    wire setup_met = (setup_cnt_ff >= SETUP_MAX);
    wire timer_clear = dual ? step_any : b_edge;
    wire setup_viol = step_any & ~setup_met & (~dual | (cw_req != last_dir_ff));
    wire overlap = dual & ((a_fall & b_level) | (b_fall & a_level) | (a_fall & b_fall));

    assign nxt_setup_cnt = timer_clear ? 12'h000 :
                           (setup_met ? setup_cnt_ff : setup_cnt_ff + 12'h001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_cnt_ff <= SETUP_MAX;
            last_dir_ff <= 1'b1;
        end else begin
            setup_cnt_ff <= nxt_setup_cnt;
            last_dir_ff <= step_any ? cw_req : last_dir_ff;
        end
    end

    // ------------------------------------------------------------------------
    // Standstill detection
    // ------------------------------------------------------------------------
    logic [15:0] idle_cnt_ff;
    logic [15:0] nxt_idle_cnt;

    wire pulses_idle = ~a_level & (~dual | ~b_level);
    wire idle_done = (idle_cnt_ff >= IDLE_MAX);

    assign nxt_idle_cnt = (!pulses_idle || step_any) ? 16'h0000 :
                          (idle_done ? idle_cnt_ff : idle_cnt_ff + 16'h0001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt_ff <= 16'h0000;
        end else begin
            idle_cnt_ff <= nxt_idle_cnt;
        end
    end

    // ------------------------------------------------------------------------
    // Control register and step total
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= spd_pkg::SPD_SINGLE;
            primary_ff <= `SPD_RST_SETTING;
            secondary_ff <= `SPD_RST_SETTING;
        end else if (wr_ctrl) begin
            mode_ff <= pwdata[`SPD_CTRL_MODE] ? spd_pkg::SPD_DUAL : spd_pkg::SPD_SINGLE;
            primary_ff <= pwdata[`SPD_CTRL_PRI_LSB +: 4];
            secondary_ff <= pwdata[`SPD_CTRL_SEC_LSB +: 4];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            steps_ff <= 32'h0000_0000;
        end else if (wr_steps) begin
            steps_ff <= pwdata;
        end else if (cw_req) begin
            steps_ff <= steps_ff + 32'h0000_0001;
        end else if (ccw_req) begin
            steps_ff <= steps_ff - 32'h0000_0001;
        end
    end

    // Sticky flags, write one to clear, a new event wins over the clear
    logic [1:0] flag_set;
    logic [1:0] flag_clr;

    assign flag_set = {overlap, setup_viol};
    assign flag_clr = wr_flags ? pwdata[1:0] : 2'b00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= 2'b00;
        end else begin
            flags_ff <= flag_set | (flags_ff & ~flag_clr);
        end
    end

    // ------------------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------------------
    logic step_cw_ff;
    logic step_ccw_ff;
    logic wind_en_ff;
    logic still_ff;
    logic home_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_cw_ff <= 1'b0;
            step_ccw_ff <= 1'b0;
            wind_en_ff <= 1'b1;
            still_ff <= 1'b0;
            home_ff <= 1'b1;
        end else begin
            step_cw_ff <= cw_req;
            step_ccw_ff <= ccw_req;
            wind_en_ff <= ~rel_level;
            still_ff <= idle_done;
            home_ff <= (nxt_pos == `SPD_RST_POS);
        end
    end

    // ------------------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------------------
    logic [31:0] ctrl_word;
    logic [31:0] status_word;
    logic [31:0] rd_mux;

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[`SPD_CTRL_MODE] = dual;
        ctrl_word[`SPD_CTRL_PRI_LSB +: 4] = primary_ff;
        ctrl_word[`SPD_CTRL_SEC_LSB +: 4] = secondary_ff;
        status_word = 32'h0000_0000;
        status_word[11:0] = pos_ff;
        status_word[`SPD_STAT_HOME] = home_ff;
        status_word[`SPD_STAT_WIND] = wind_en_ff;
        status_word[`SPD_STAT_RES] = res_level;
        status_word[`SPD_STAT_STILL] = still_ff;
    end

    assign rd_mux = hit_ctrl ? ctrl_word :
                    hit_status ? status_word :
                    hit_steps ? steps_ff :
                    hit_flags ? {30'h0000_0000, flags_ff} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= setup_phase;
            pslverr_ff <= setup_phase & ~hit_any;
            prdata_ff <= (setup_phase & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign step_cw = step_cw_ff;
    assign step_ccw = step_ccw_ff;
    assign winding_enable = wind_en_ff;
    assign standstill_current = still_ff;
    assign excitation_home_flag = home_ff;
    assign excitation_position = pos_ff;

endmodule

// ==== pkg/spd_cfg.svh ====
// Constants of the step pulse input decoder: register map, fields, resets, timing.
// Assumes inclusion by bare name from the design files.
`ifndef SPD_CFG_SVH
`define SPD_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define SPD_ADDR_CTRL 8'h00
`define SPD_ADDR_STATUS 8'h04
`define SPD_ADDR_STEPS 8'h08
`define SPD_ADDR_FLAGS 8'h0C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SPD_CTRL_MODE 0
`define SPD_CTRL_PRI_LSB 4
`define SPD_CTRL_SEC_LSB 8
`define SPD_STAT_HOME 16
`define SPD_STAT_WIND 17
`define SPD_STAT_RES 18
`define SPD_STAT_STILL 19
`define SPD_FLAG_SETUP 0
`define SPD_FLAG_OVERLAP 1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SPD_RST_SETTING 4'h0
`define SPD_RST_WRAP 12'h00A
`define SPD_RST_POS 12'h000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SPD_CLK_MHZ 250
`define SPD_DIR_SETUP_NS 10000
`define SPD_IDLE_CYCLES 1000

`endif

// ==== pkg/spd_pkg.sv ====
// Types shared by the step pulse input decoder files.
// Assumes nothing of its surroundings.
package spd_pkg;

    typedef logic [3:0] spd_setting_t;
    typedef logic [11:0] spd_pos_t;

    typedef enum logic [1:0] {
        SPD_SINGLE = 2'b01,
        SPD_DUAL = 2'b10
    } spd_mode_e;

endpackage

// ==== hw/spd_wrap_rom.sv ====
// Lookup of the microstep count spanning ten full steps per resolution setting.
// Assumes pclk domain; read data come out of a register, one cycle late.
`timescale 1ns/10ps
`include "spd_cfg.svh"

module spd_wrap_rom (
    input wire logic pclk,
    input wire logic presetn,
    input wire spd_pkg::spd_setting_t setting,
    output spd_pkg::spd_pos_t wrap_ff
);

    spd_pkg::spd_pos_t nxt_wrap;

    // ------------------------------------------------------------------------
    // Ten full steps times divisions
    // ------------------------------------------------------------------------
    always_comb begin
        unique case (setting)
            4'h0: nxt_wrap = 12'h00A;
            4'h1: nxt_wrap = 12'h014;
            4'h2: nxt_wrap = 12'h019;
            4'h3: nxt_wrap = 12'h028;
            4'h4: nxt_wrap = 12'h032;
            4'h5: nxt_wrap = 12'h050;
            4'h6: nxt_wrap = 12'h064;
            4'h7: nxt_wrap = 12'h0C8;
            4'h8: nxt_wrap = 12'h0FA;
            4'h9: nxt_wrap = 12'h190;
            4'hA: nxt_wrap = 12'h1F4;
            4'hB: nxt_wrap = 12'h320;
            4'hC: nxt_wrap = 12'h3E8;
            4'hD: nxt_wrap = 12'h4E2;
            4'hE: nxt_wrap = 12'h7D0;
            4'hF: nxt_wrap = 12'h9C4;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wrap_ff <= `SPD_RST_WRAP;
        end else begin
            wrap_ff <= nxt_wrap;
        end
    end

endmodule

// ==== verif/spd_step_checker.sv ====
// Port checker of the step decoder: stepping, position, home flag, windings.
// Assumes binding into spd_step_decoder; pin mode follows CTRL writes.
`timescale 1ns/10ps
module spd_step_checker #(
    parameter int IDLE_CYCLES = 1000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pulse_pin_a,
    input wire logic pulse_pin_b,
    input wire logic windings_release,
    input wire logic step_cw,
    input wire logic step_ccw,
    input wire logic winding_enable,
    input wire logic excitation_home_flag,
    input wire logic [11:0] excitation_position
);
    logic dual_ff;
    logic [11:0] pos_w;
    assign pos_w = excitation_position;

    // Pin mode mirror
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dual_ff <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == 8'h00) begin
            dual_ff <= pwdata[0];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    single_cw_a: assert property (
        !dual_ff && $fell(pulse_pin_a) && pulse_pin_b |-> ##[2:4] step_cw)
        else $error("cw step missing in single mode");
    single_ccw_a: assert property (
        !dual_ff && $fell(pulse_pin_a) && !pulse_pin_b |-> ##[2:4] step_ccw)
        else $error("ccw step missing in single mode");
    dual_cw_a: assert property (
        dual_ff && $fell(pulse_pin_a) && !$past(pulse_pin_b) |-> ##[2:4] step_cw)
        else $error("cw step missing in dual mode");
    dual_ccw_a: assert property (
        dual_ff && $fell(pulse_pin_b) && !$past(pulse_pin_a) |-> ##[2:4] step_ccw)
        else $error("ccw step missing in dual mode");
    step_once_a: assert property (
        step_cw || step_ccw |=> !step_cw && !step_ccw)
        else $error("step pulse longer than one cycle");
    home_flag_a: assert property (
        excitation_home_flag == (pos_w == 12'h000))
        else $error("home flag disagrees with position");
    reset_home_a: assert property (
        $rose(presetn) |-> excitation_home_flag && pos_w == 12'h000)
        else $error("position not home after reset");
    pos_up_a: assert property (
        step_cw |-> pos_w == $past(pos_w) + 12'h001 || pos_w == 12'h000)
        else $error("position did not count up");
    pos_down_a: assert property (
        step_ccw |-> pos_w == $past(pos_w) - 12'h001 || $past(pos_w) == 12'h000)
        else $error("position did not count down");
    wind_off_a: assert property (
        windings_release [*4] |-> !winding_enable)
        else $error("winding current not cut");
    wind_on_a: assert property (
        !windings_release [*4] |-> winding_enable)
        else $error("winding current not restored");
endmodule

bind spd_step_decoder spd_step_checker #(.IDLE_CYCLES(IDLE_CYCLES)) u_spd_step_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pulse_pin_a(pulse_pin_a),
    .pulse_pin_b(pulse_pin_b), .windings_release(windings_release), .step_cw(step_cw),
    .step_ccw(step_ccw), .winding_enable(winding_enable),
    .excitation_home_flag(excitation_home_flag), .excitation_position(excitation_position));

// ==== verif/spd_pulse_ctrl_model.sv ====
// Pulse-train controller model driving the decoder's pins.
// Assumes the decoder's pclk; its tasks are called by the bench.
`timescale 1ns/10ps
module spd_pulse_ctrl_model (
    input wire logic pclk,
    output logic pin_a,
    output logic pin_b,
    output logic release_pin,
    output logic res_pin
);
    logic dir_ff = 1'b1;
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
        release_pin = 1'b0;
        res_pin = 1'b0;
    end

    task automatic gap(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Steps of one direction; hi sets the speed
    task automatic move(input logic dual, input logic cw, input int n, input int hi);
        logic chg;
        chg = (cw != dir_ff) || (!dual && pin_b != cw);
        @(posedge pclk);
        pin_b <= dual ? 1'b0 : cw;
        gap(chg ? 2600 : 1);
        dir_ff = cw;
        repeat (n) begin
            pin_a <= !dual || cw;
            pin_b <= dual ? !cw : cw;
            gap(hi);
            pin_a <= 1'b0;
            pin_b <= dual ? 1'b0 : cw;
            gap(3);
        end
    endtask

    task automatic park();
        pin_b <= 1'b0;
        gap(3);
    endtask

    // Deliberate fault: both pulse pins at once
    task automatic both();
        pin_a <= 1'b1;
        pin_b <= 1'b1;
        gap(3);
        pin_a <= 1'b0;
        pin_b <= 1'b0;
        gap(4);
    endtask

    // Deliberate fault: dual mode ccw pulse right after a cw pulse
    task automatic rush();
        pin_b <= 1'b1;
        gap(2);
        pin_b <= 1'b0;
        gap(3);
    endtask

    task automatic wind(input logic v);
        release_pin <= v;
        gap(v ? 4 : 50);
    endtask

    // Caller keeps the motor stopped at home
    task automatic res(input logic v);
        res_pin <= v;
        gap(4);
    endtask
endmodule

// ==== verif/tb_step_pulse_input_decoder.sv ====
// Self-checking bench of the step decoder with a pulse controller model.
// Assumes the checker binds itself; IDLE_CYCLES shortened to 8.
`timescale 1ns/10ps
`include "spd_cfg.svh"
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end
module tb_step_pulse_input_decoder;
    typedef struct {
        logic dual;
        logic cw;
        int n;
        logic [11:0] pos;
        logic home;
    } spd_row_s;
    spd_row_s rows[5] = '{
        '{1'b0, 1'b1, 3, 12'h003, 1'b0},
        '{1'b0, 1'b0, 5, 12'h008, 1'b0},
        '{1'b1, 1'b1, 2, 12'h000, 1'b1},
        '{1'b1, 1'b0, 1, 12'h009, 1'b0},
        '{1'b0, 1'b1, 11, 12'h000, 1'b1}};
    int num_errors = 0;
    int compares = 0;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, step_cw, step_ccw, winding_enable, standstill_current;
    logic excitation_home_flag, pin_a, pin_b, rel, res;
    logic [11:0] excitation_position;

    always #2 pclk = ~pclk;

    spd_step_decoder #(.IDLE_CYCLES(8)) u_spd_step_decoder (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pulse_pin_a(pin_a), .pulse_pin_b(pin_b),
        .windings_release(rel), .resolution_select(res), .step_cw(step_cw),
        .step_ccw(step_ccw), .winding_enable(winding_enable),
        .standstill_current(standstill_current),
        .excitation_home_flag(excitation_home_flag),
        .excitation_position(excitation_position));
    spd_pulse_ctrl_model u_spd_pulse_ctrl_model (
        .pclk(pclk), .pin_a(pin_a), .pin_b(pin_b), .release_pin(rel), .res_pin(res));

    task automatic tally_and_finish();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            num_errors++;
            tally_and_finish();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp,
                          input logic [31:0] msk, input logic experr);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        `CHK(nm, exp, q & msk)
        `CHK(nm, experr, e)
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge pclk);
        `CHK("home_in_reset", 1'b1, excitation_home_flag)
        presetn <= 1'b1;
        rd_chk("ctrl_rst", `SPD_ADDR_CTRL, 32'h0, 32'hFFFFFFFF, 1'b0);
        rd_chk("status_rst", `SPD_ADDR_STATUS, 32'h0003_0000, 32'h0007_0FFF, 1'b0);
        rd_chk("unmapped", 8'h10, 32'h0, 32'hFFFFFFFF, 1'b1);
        for (int i = 0; i < 5; i++) begin
            u_spd_pulse_ctrl_model.park();
            apb_wr(`SPD_ADDR_CTRL, {31'h0, rows[i].dual});
            u_spd_pulse_ctrl_model.move(rows[i].dual, rows[i].cw, rows[i].n, (i % 2) ? 6 : 2);
            repeat (8) @(posedge pclk);
            `CHK("position", rows[i].pos, excitation_position)
            `CHK("home", rows[i].home, excitation_home_flag)
        end
        rd_chk("steps", `SPD_ADDR_STEPS, 32'h0000_000A, 32'hFFFFFFFF, 1'b0);
        // Secondary setting 1 spans twenty microsteps
        apb_wr(`SPD_ADDR_CTRL, 32'h0000_0100);
        u_spd_pulse_ctrl_model.res(1'b1);
        rd_chk("res_status", `SPD_ADDR_STATUS, 32'h0007_0000, 32'h0007_0000, 1'b0);
        u_spd_pulse_ctrl_model.move(1'b0, 1'b1, 10, 2);
        repeat (8) @(posedge pclk);
        `CHK("res_pos", 12'h00A, excitation_position)
        u_spd_pulse_ctrl_model.move(1'b0, 1'b1, 10, 3);
        repeat (8) @(posedge pclk);
        `CHK("res_home", 1'b1, excitation_home_flag)
        u_spd_pulse_ctrl_model.res(1'b0);
        u_spd_pulse_ctrl_model.wind(1'b1);
        repeat (2) @(posedge pclk);
        `CHK("wind_off", 1'b0, winding_enable)
        u_spd_pulse_ctrl_model.wind(1'b0);
        `CHK("wind_on", 1'b1, winding_enable)
        u_spd_pulse_ctrl_model.park();
        apb_wr(`SPD_ADDR_CTRL, 32'h0000_0001);
        u_spd_pulse_ctrl_model.both();
        `CHK("moving", 1'b0, standstill_current)
        repeat (20) @(posedge pclk);
        `CHK("overlap_pos", 12'h000, excitation_position)
        `CHK("standstill", 1'b1, standstill_current)
        rd_chk("flags", `SPD_ADDR_FLAGS, 32'h2, 32'h2, 1'b0);
        apb_wr(`SPD_ADDR_FLAGS, 32'h0000_0003);
        apb_wr(`SPD_ADDR_STEPS, 32'h0000_0005);
        rd_chk("flags_clr", `SPD_ADDR_FLAGS, 32'h0, 32'h3, 1'b0);
        u_spd_pulse_ctrl_model.move(1'b1, 1'b1, 3, 2);
        u_spd_pulse_ctrl_model.rush();
        repeat (8) @(posedge pclk);
        `CHK("pre_rst_pos", 12'h002, excitation_position)
        rd_chk("flags_setup", `SPD_ADDR_FLAGS, 32'h1, 32'h3, 1'b0);
        rd_chk("steps_wr", `SPD_ADDR_STEPS, 32'h0000_0007, 32'hFFFFFFFF, 1'b0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK("rst_pos", 12'h000, excitation_position)
        `CHK("rst_home", 1'b1, excitation_home_flag)
        presetn <= 1'b1;
        rd_chk("steps_rst", `SPD_ADDR_STEPS, 32'h0, 32'hFFFFFFFF, 1'b0);
        repeat (4) @(posedge pclk);
        tally_and_finish();
    end
endmodule
